// >>> hdl/fieldbus_error_flag_monitor.sv
// Error flag collector of the fieldbus master with a Wishbone register port.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps

module fieldbus_error_flag_monitor #(
  parameter int MAX_SLAVES = 80
) (
  // Clock, reset, enable
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        CE_I,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Fault events from the link engine, one-cycle pulses, and the slave count
  input  wire logic        PD_FAULT_I,
  input  wire logic        FAULT_ALL_I,
  input  wire logic [6:0]  FAULT_NODE_I,
  input  wire logic        CFG_MISMATCH_I,
  input  wire logic        TOPO_BAD_I,
  input  wire logic [6:0]  SLAVE_CNT_I,
  input  wire logic        PARAM_BAD_I,
  input  wire logic        SEND_FAIL_I,
  input  wire logic        LINK_FAIL_I,
  input  wire logic        DUP_ADDR_I,
  input  wire logic        INIT_FAIL_I,
  input  wire logic        AL_ERR_I,
  // Cycle tick and frame reception
  input  wire logic        CYCLE_I,
  input  wire logic        FRAME_RX_I,
  // Exchange control and interrupt
  output logic             STOP_ALL_O,
  output logic      [79:0] STOP_NODE_O,
  output logic             IRQ_O
);

  localparam int NC = fbmon_pkg::NODE_CNT;
  localparam int FC = fbmon_pkg::FLAG_CNT;
  localparam int TW = fbmon_pkg::THR_W;

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic          stop_mode_q;
  logic [TW-1:0] thr_q;
  logic [FC-1:0] mask_q;
  logic [TW-1:0] miss_q;
  logic [TW-1:0] miss_d;
  logic          err_reset_q;
  logic [FC-1:0] flags_q;
  logic [NC-1:0] nodes_q;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire        bus_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire        bus_wr   = bus_req & WB_WE_I & CE_I;
  wire [31:0] byte_msk = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                          {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire [31:0] wr_bits  = WB_DAT_I & byte_msk;
  wire        hit_ctrl = WB_ADR_I == fbmon_pkg::CTRL_OFS;
  wire        hit_thr  = WB_ADR_I == fbmon_pkg::THR_OFS;
  wire        hit_flg  = WB_ADR_I == fbmon_pkg::FLAGS_OFS;
  wire        hit_mask = WB_ADR_I == fbmon_pkg::MASK_OFS;
  wire        hit_n0   = WB_ADR_I == fbmon_pkg::NODE0_OFS;
  wire        hit_n1   = WB_ADR_I == fbmon_pkg::NODE1_OFS;
  wire        hit_n2   = WB_ADR_I == fbmon_pkg::NODE2_OFS;
  wire        hit_stat = WB_ADR_I == fbmon_pkg::STAT_OFS;
  wire        wr_ctrl  = bus_wr & hit_ctrl;
  wire        wr_thr   = bus_wr & hit_thr;
  wire        wr_mask  = bus_wr & hit_mask;
  wire        wr_flg   = bus_wr & hit_flg;

  // Write-one pulse, not stored as a setting.
  wire        reset_cmd = wr_ctrl & wr_bits[fbmon_pkg::CTRL_RESET_BIT];

  // ****************************************************************
  // Reception timeout counter
  // ****************************************************************
  // Consecutive cycles without a frame; a received frame restarts it.
  always_comb begin
    miss_d = miss_q;
    if (CYCLE_I) begin
      if (FRAME_RX_I) begin
        miss_d = '0;
      end else if (miss_q != '1) begin
        miss_d = miss_q + TW'(1);
      end
    end
  end

  // The flag keeps being re-set while the count stays above threshold.
  wire to_over = miss_q > thr_q;

  // ****************************************************************
  // Fault classification
  // ****************************************************************
  wire pd_event  = PD_FAULT_I | to_over;
  // Timeout concerns every slave, so it always counts as all-slave.
  wire pd_all    = to_over | (PD_FAULT_I & FAULT_ALL_I);
  wire pd_fatal  = pd_event & (stop_mode_q | pd_all);
  wire pd_nonfat = pd_event & ~pd_fatal;
  wire too_many  = 32'(SLAVE_CNT_I) > 32'(MAX_SLAVES);
  wire node_ok   = PD_FAULT_I & (FAULT_NODE_I != 7'h00) &
                   (32'(FAULT_NODE_I) <= NC);

  wire [NC-1:0] node_set = node_ok ?
                           (NC'(1) << (FAULT_NODE_I - 7'h01)) :
                           '0;

  logic [FC-1:0] flag_set;
  always_comb begin
    flag_set                       = '0;
    flag_set[fbmon_pkg::F_FATAL]   = pd_fatal;
    flag_set[fbmon_pkg::F_NONFATAL] = pd_nonfat & ~flags_q[fbmon_pkg::F_FATAL];
    flag_set[fbmon_pkg::F_VERIFY]  = CFG_MISMATCH_I;
    flag_set[fbmon_pkg::F_UNSUP]   = TOPO_BAD_I | too_many;
    flag_set[fbmon_pkg::F_PD]      = pd_event;
    flag_set[fbmon_pkg::F_RXTO]    = to_over;
    flag_set[fbmon_pkg::F_PARAM]   = PARAM_BAD_I;
    flag_set[fbmon_pkg::F_SEND]    = SEND_FAIL_I;
    flag_set[fbmon_pkg::F_LINK]    = LINK_FAIL_I;
    flag_set[fbmon_pkg::F_DUP]     = DUP_ADDR_I;
    flag_set[fbmon_pkg::F_INIT]    = INIT_FAIL_I;
    flag_set[fbmon_pkg::F_AL]      = AL_ERR_I;
  end

  // Fatal wipes a standing non-fatal so the two never coexist.
  logic [FC-1:0] flag_clr;
  always_comb begin
    flag_clr = {FC{err_reset_q}};
    if (wr_flg) begin
      flag_clr = flag_clr | wr_bits[FC-1:0];
    end
    flag_clr[fbmon_pkg::F_NONFATAL] = flag_clr[fbmon_pkg::F_NONFATAL] |
                                      pd_fatal;
  end

  // ****************************************************************
  // Sticky flag and node tables
  // ****************************************************************
  sticky_bits #(.W(FC)) u_flags (
    .clk_i (MCLK_I),
    .rst_i (SYS_RST_I),
    .ce_i  (CE_I),
    .set_i (flag_set),
    .clr_i (flag_clr),
    .q_o   (flags_q)
  );

  // Node bits are cleared only by the error reset command.
  sticky_bits #(.W(NC)) u_nodes (
    .clk_i (MCLK_I),
    .rst_i (SYS_RST_I),
    .ce_i  (CE_I),
    .set_i (node_set),
    .clr_i ({NC{err_reset_q}}),
    .q_o   (nodes_q)
  );

  // ****************************************************************
  // Control registers and exchange stop
  // ****************************************************************
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      stop_mode_q <= fbmon_pkg::STOP_RST;
      thr_q       <= fbmon_pkg::THR_RST;
      mask_q      <= fbmon_pkg::MASK_RST;
      miss_q      <= '0;
      err_reset_q <= 1'b0;
    end else if (CE_I) begin
      if (wr_ctrl) begin
        stop_mode_q <= wr_bits[fbmon_pkg::CTRL_STOP_BIT];
      end
      if (wr_thr) begin
        thr_q <= wr_bits[TW-1:0];
      end
      if (wr_mask) begin
        mask_q <= wr_bits[FC-1:0];
      end
      miss_q      <= miss_d;
      err_reset_q <= reset_cmd;
    end
  end

  // A fatal fault halts every slave until the error reset.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      STOP_ALL_O <= 1'b0;
    end else if (CE_I) begin
      if (pd_fatal) begin
        STOP_ALL_O <= 1'b1;
      end else if (err_reset_q) begin
        STOP_ALL_O <= 1'b0;
      end
    end
  end

  // Per-slave stop mirrors the table bits, one edge after them.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      STOP_NODE_O <= '0;
      IRQ_O       <= 1'b0;
    end else if (CE_I) begin
      STOP_NODE_O <= nodes_q;
      IRQ_O       <= |(flags_q & mask_q);
    end
  end

  // ****************************************************************
  // Read path and acknowledge
  // ****************************************************************
  wire [31:0] rd_ctrl = 32'(stop_mode_q);
  wire [31:0] rd_stat = {miss_q, 15'h0000, STOP_ALL_O};
  wire [31:0] rd_n0   = {16'h0000, nodes_q[15:0]};
  wire [31:0] rd_n1   = nodes_q[47:16];
  wire [31:0] rd_n2   = nodes_q[79:48];
  wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                        hit_thr  ? 32'(thr_q) :
                        hit_flg  ? 32'(flags_q) :
                        hit_mask ? 32'(mask_q) :
                        hit_n0   ? rd_n0 :
                        hit_n1   ? rd_n1 :
                        hit_n2   ? rd_n2 :
                        hit_stat ? rd_stat : 32'h0000_0000;

  // Registered answer: ack one edge after the request, then drop.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else if (CE_I) begin
      WB_ACK_O <= bus_req;
      if (bus_req) begin
        WB_DAT_O <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  fatal_excl_a: assert property (
    !(flags_q[fbmon_pkg::F_FATAL] && flags_q[fbmon_pkg::F_NONFATAL])
  ) else $error("Fatal and non-fatal flags set together.");

  stop_mode_a: assert property (
    CE_I && pd_event && stop_mode_q
    |=> flags_q[fbmon_pkg::F_FATAL] && STOP_ALL_O
  ) else $error("Stop mode fault did not stop all slaves.");

  // A standing all-slave stop may outlive a fatal flag cleared by W1C.
  nonfatal_a: assert property (
    CE_I && PD_FAULT_I && !FAULT_ALL_I && !stop_mode_q && !to_over &&
    !flags_q[fbmon_pkg::F_FATAL]
    |=> flags_q[fbmon_pkg::F_NONFATAL] && !$rose(STOP_ALL_O)
  ) else $error("Single-slave fault not flagged non-fatal.");

  node_bit_a: assert property (
    CE_I && node_ok |=> ((nodes_q & $past(node_set)) == $past(node_set))
    ##1 (!$past(CE_I) ||
         (STOP_NODE_O & $past(node_set, 2)) == $past(node_set, 2))
  ) else $error("Node error bit not set or stop missed.");

  general_pd_a: assert property (
    CE_I && pd_event |=> flags_q[fbmon_pkg::F_PD]
  ) else $error("General process data flag missing.");

  cause_a: assert property (
    CE_I && |flag_set[FC-1:2]
    |=> (flags_q[FC-1:2] & $past(flag_set[FC-1:2])) ==
        $past(flag_set[FC-1:2])
  ) else $error("Cause flag not set by its event.");

  timeout_a: assert property (
    CE_I && CYCLE_I && !FRAME_RX_I && miss_q == thr_q &&
    thr_q != '1 && !wr_thr
    ##1 CE_I |=> flags_q[fbmon_pkg::F_RXTO]
  ) else $error("Reception timeout not flagged.");

  rx_restart_a: assert property (
    CE_I && CYCLE_I && FRAME_RX_I |=> miss_q == '0
  ) else $error("Received frame did not restart the miss count.");

  unsup_a: assert property (
    CE_I && (TOPO_BAD_I || too_many) |=> flags_q[fbmon_pkg::F_UNSUP]
  ) else $error("Unsupported configuration not flagged.");

  clear_a: assert property (
    CE_I && err_reset_q && flag_set == '0 && node_set == '0
    |=> flags_q == '0 && nodes_q == '0
  ) else $error("Error reset left flags standing.");

  // No flag other than non-fatal may fall unless an error reset or a flag register write came.
  flag_hold_a: assert property (
    CE_I && !err_reset_q && !wr_flg
    |=> (flags_q[FC-1:1] & $past(flags_q[FC-1:1])) ==
        $past(flags_q[FC-1:1])
  ) else $error("Error flag dropped without a clear.");

  node_hold_a: assert property (
    CE_I && !err_reset_q |=> (nodes_q & $past(nodes_q)) == $past(nodes_q)
  ) else $error("Node error bit dropped without error reset.");

  stop_hold_a: assert property (
    CE_I && STOP_ALL_O && !err_reset_q |=> STOP_ALL_O
  ) else $error("All-slave stop released without error reset.");

  ack_a: assert property (
    WB_ACK_O && CE_I |=> !WB_ACK_O
  ) else $error("Acknowledge held longer than one cycle.");

  fatal_c: cover property (CE_I && pd_fatal ##1 STOP_ALL_O);
  nonfatal_c: cover property (CE_I && pd_nonfat ##1 !STOP_ALL_O);
  timeout_c: cover property (flags_q[fbmon_pkg::F_RXTO]);
  reset_c: cover property (STOP_ALL_O ##1 err_reset_q ##1 !STOP_ALL_O);
  node_c: cover property (CE_I && node_ok ##2 |STOP_NODE_O);

endmodule : fieldbus_error_flag_monitor

// >>> inc/fbmon_pkg.sv
// Package with register map, field positions and reset values of the monitor.
package fbmon_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NODE_CNT   = 80;
  localparam int NODE_IDX_W = 7;
  localparam int FLAG_CNT   = 12;
  localparam int THR_W      = 16;
  localparam int ADR_W      = 8;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] THR_OFS    = 8'h04;
  localparam logic [7:0] FLAGS_OFS  = 8'h08;
  localparam logic [7:0] MASK_OFS   = 8'h0c;
  localparam logic [7:0] NODE0_OFS  = 8'h10;
  localparam logic [7:0] NODE1_OFS  = 8'h14;
  localparam logic [7:0] NODE2_OFS  = 8'h18;
  localparam logic [7:0] STAT_OFS   = 8'h1c;

  // ****************************************************************
  // Control and status bits
  // ****************************************************************
  localparam int CTRL_STOP_BIT  = 0;
  localparam int CTRL_RESET_BIT = 1;
  localparam int STAT_ALL_BIT   = 0;
  localparam int STAT_CNT_LSB   = 16;

  // ****************************************************************
  // Error flag positions
  // ****************************************************************
  localparam int F_NONFATAL = 0;
  localparam int F_FATAL    = 1;
  localparam int F_VERIFY   = 2;
  localparam int F_UNSUP    = 3;
  localparam int F_PD       = 4;
  localparam int F_RXTO     = 5;
  localparam int F_PARAM    = 6;
  localparam int F_SEND     = 7;
  localparam int F_LINK     = 8;
  localparam int F_DUP      = 9;
  localparam int F_INIT     = 10;
  localparam int F_AL       = 11;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [THR_W-1:0]    THR_RST  = 16'h0003;
  localparam logic [FLAG_CNT-1:0] MASK_RST = 12'h000;
  localparam logic                STOP_RST = 1'h0;

endpackage : fbmon_pkg

// >>> hdl/sticky_bits.sv
// Vector of sticky flags where a set in the same cycle beats a clear.
`timescale 1ns/100ps

module sticky_bits #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Set and clear vectors
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  // Held flags
  output logic      [W-1:0] q_o
);

  logic [W-1:0] q_d;

  // A new event is never lost to a clear arriving in the same cycle.
  assign q_d = (q_o & ~clr_i) | set_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else if (ce_i) begin
      q_o <= q_d;
    end
  end

endmodule : sticky_bits

// >>> dv/slave_net_model.sv
// Model of the fieldbus slaves and link engine that raise fault events.
`timescale 1ns/100ps

module slave_net_model (
  // Clock
  input  wire logic       clk_i,
  // Fault events
  output logic            pd_fault_o,
  output logic            fault_all_o,
  output logic [6:0]      fault_node_o,
  output logic [7:0]      cause_o,
  output logic [6:0]      slave_cnt_o,
  // Cycle ticks
  output logic            cycle_o,
  output logic            frame_rx_o
);
  initial begin
    pd_fault_o   = 1'b0;
    fault_all_o  = 1'b0;
    fault_node_o = 7'h00;
    cause_o      = 8'h00;
    slave_cnt_o  = 7'h50;
    cycle_o      = 1'b0;
    frame_rx_o   = 1'b0;
  end

  // Code 0 is a process-data fault, 1 to 8 a cause, 9 one slave too many.
  // Qualifiers turn to their inverse afterwards so no stale value lingers.
  task automatic pulse(input int code, input logic [6:0] node,
                       input logic all);
    pd_fault_o   <= (code == 0);
    fault_all_o  <= all;
    fault_node_o <= node;
    cause_o      <= (code > 0 && code < 9) ? 8'(1 << (code - 1)) : 8'h00;
    slave_cnt_o  <= (code == 9) ? 7'h51 : 7'h50;
    @(posedge clk_i);
    pd_fault_o   <= 1'b0;
    fault_all_o  <= ~all;
    fault_node_o <= ~node;
    cause_o      <= 8'h00;
    slave_cnt_o  <= 7'h50;
    @(posedge clk_i);
  endtask : pulse

  // One communication cycle per call round, frame seen or missed.
  task automatic cycles(input int n, input logic rx);
    repeat (n) begin
      cycle_o    <= 1'b1;
      frame_rx_o <= rx;
      @(posedge clk_i);
      cycle_o    <= 1'b0;
      frame_rx_o <= ~rx;
      @(posedge clk_i);
    end
  endtask : cycles
endmodule : slave_net_model

// >>> dv/fieldbus_error_flag_monitor_test.sv
// Self-checking bench for the fieldbus error flag monitor.
`timescale 1ns/100ps

module fieldbus_error_flag_monitor_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic        ce  = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] r;
  logic        ack;
  logic        stop_all;
  logic        irq;
  logic [79:0] stop_node;
  logic        pd;
  logic        all;
  logic [6:0]  node;
  logic [6:0]  scnt;
  logic [7:0]  cause;
  logic        tick;
  logic        frx;
  int          fails = 0;
  int          n_checks = 0;
  int          cause_bit [9] = '{
    fbmon_pkg::F_VERIFY,
    fbmon_pkg::F_UNSUP,
    fbmon_pkg::F_PARAM,
    fbmon_pkg::F_SEND,
    fbmon_pkg::F_LINK,
    fbmon_pkg::F_DUP,
    fbmon_pkg::F_INIT,
    fbmon_pkg::F_AL,
    fbmon_pkg::F_UNSUP};

  always #4 clk = ~clk;

  fieldbus_error_flag_monitor dut (
    .MCLK_I(clk), .SYS_RST_I(rst), .CE_I(ce),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .PD_FAULT_I(pd), .FAULT_ALL_I(all), .FAULT_NODE_I(node),
    .CFG_MISMATCH_I(cause[0]), .TOPO_BAD_I(cause[1]), .SLAVE_CNT_I(scnt),
    .PARAM_BAD_I(cause[2]), .SEND_FAIL_I(cause[3]),
    .LINK_FAIL_I(cause[4]), .DUP_ADDR_I(cause[5]),
    .INIT_FAIL_I(cause[6]), .AL_ERR_I(cause[7]),
    .CYCLE_I(tick), .FRAME_RX_I(frx),
    .STOP_ALL_O(stop_all), .STOP_NODE_O(stop_node), .IRQ_O(irq));

  slave_net_model net (
    .clk_i(clk), .pd_fault_o(pd), .fault_all_o(all), .fault_node_o(node),
    .cause_o(cause), .slave_cnt_o(scnt), .cycle_o(tick), .frame_rx_o(frx));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Entered just after a rising edge; the request stands until ack.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= 4'hf;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    chk("ack", 32'h1, {31'h0, ack});
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), exp, r);
  endtask : rd

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(fbmon_pkg::CTRL_OFS, 32'h0);
    rd(fbmon_pkg::THR_OFS, {16'h0, fbmon_pkg::THR_RST});
    rd(fbmon_pkg::FLAGS_OFS, 32'h0);
    wb(1'b1, 8'h24, 32'hffff_ffff);
    rd(8'h24, 32'h0);
    rd(fbmon_pkg::MASK_OFS, 32'h0);
    wb(1'b1, fbmon_pkg::MASK_OFS, 32'h1);
    net.pulse(0, 7'd5, 1'b0);
    rd(fbmon_pkg::FLAGS_OFS, 32'h11);
    rd(fbmon_pkg::NODE0_OFS, 32'h10);
    chk("stop_node", 32'h10, stop_node[31:0]);
    chk("stop_all", 32'h0, {31'h0, stop_all});
    chk("irq", 32'h1, {31'h0, irq});
    net.pulse(0, 7'd17, 1'b0);
    net.pulse(0, 7'd80, 1'b0);
    rd(fbmon_pkg::NODE1_OFS, 32'h1);
    rd(fbmon_pkg::NODE2_OFS, 32'h8000_0000);
    chk("stop_node", 32'h8000_0000, stop_node[79:48]);
    net.pulse(0, 7'd3, 1'b1);
    rd(fbmon_pkg::FLAGS_OFS, 32'h12);
    chk("stop_all", 32'h1, {31'h0, stop_all});
    chk("irq", 32'h0, {31'h0, irq});
    wb(1'b1, fbmon_pkg::FLAGS_OFS, 32'h12);
    rd(fbmon_pkg::FLAGS_OFS, 32'h0);
    rd(fbmon_pkg::NODE0_OFS, 32'h14);
    wb(1'b1, fbmon_pkg::CTRL_OFS, 32'h2);
    rd(fbmon_pkg::NODE0_OFS, 32'h0);
    chk("stop_all", 32'h0, {31'h0, stop_all});
    wb(1'b1, fbmon_pkg::CTRL_OFS, 32'h1);
    net.pulse(0, 7'd5, 1'b0);
    rd(fbmon_pkg::FLAGS_OFS, 32'h12);
    chk("stop_all", 32'h1, {31'h0, stop_all});
    wb(1'b1, fbmon_pkg::CTRL_OFS, 32'h2);
    wb(1'b1, fbmon_pkg::MASK_OFS, 32'hfff);
    for (int i = 1; i < 10; i++) begin
      net.pulse(i, 7'd0, 1'b0);
      wb(1'b0, fbmon_pkg::FLAGS_OFS, 32'h0);
      chk("cause", 32'h1, 32'((r >> cause_bit[i - 1]) & 32'h1));
      chk("irq", 32'h1, {31'h0, irq});
      wb(1'b1, fbmon_pkg::CTRL_OFS, 32'h2);
      rd(fbmon_pkg::FLAGS_OFS, 32'h0);
    end
    // With the enable low a fault must leave no trace at all.
    ce <= 1'b0;
    net.pulse(0, 7'd5, 1'b1);
    ce <= 1'b1;
    rd(fbmon_pkg::FLAGS_OFS, 32'h0);
    rd(fbmon_pkg::NODE0_OFS, 32'h0);
    chk("stop_all", 32'h0, {31'h0, stop_all});
    net.cycles(3, 1'b0);
    rd(fbmon_pkg::STAT_OFS, 32'h0003_0000);
    rd(fbmon_pkg::FLAGS_OFS, 32'h0);
    net.cycles(1, 1'b0);
    rd(fbmon_pkg::FLAGS_OFS, 32'h32);
    rd(fbmon_pkg::STAT_OFS, 32'h0004_0001);
    net.cycles(1, 1'b1);
    wb(1'b1, fbmon_pkg::CTRL_OFS, 32'h2);
    rd(fbmon_pkg::FLAGS_OFS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    complete_run();
  end
endmodule : fieldbus_error_flag_monitor_test
